// ### pkg/ovf_timer_pkg.sv
// Constants shared by the prescaled overflow counter and its helpers
package ovf_timer_pkg;

    // Clock and instruction timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int INSTR_PERIOD_NS = 200;
    localparam int CLKS_PER_INSTR  = INSTR_PERIOD_NS / CLK_PERIOD_NS;
    localparam int INHIBIT_INSTR   = 2;
    localparam int INHIBIT_CLKS    = INHIBIT_INSTR * CLKS_PER_INSTR;
    localparam logic [3:0] INHIBIT_LOAD = 4'(INHIBIT_CLKS);

    // Phase codes within one instruction cycle (four clocks)
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

    // Register byte offsets
    localparam logic [4:0] OFF_COUNT  = 5'h00;
    localparam logic [4:0] OFF_OPTION = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_CLEAR  = 5'h0c;
    localparam logic [4:0] OFF_ENABLE = 5'h10;

    // Option field positions
    localparam int CFG_CS_BIT    = 5;
    localparam int CFG_SE_BIT    = 4;
    localparam int CFG_PSA_BIT   = 3;
    localparam int CFG_RATIO_LSB = 0;
    localparam int CFG_RATIO_W   = 3;

    // Interrupt control field positions
    localparam int FLAG_BIT = 2;
    localparam int EN_BIT   = 5;

    // Reset values and limits
    localparam logic [5:0] CFG_RESET   = 6'h3f;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX   = 8'hff;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### pkg/timer_path_if.sv
// Signals between the counter core, the shared prescaler and the phase sampler
`timescale 1ns/1ps
interface timer_path_if;
    logic       src_level;
    logic       clear;
    logic       hold;
    logic       to_counter;
    logic [2:0] ratio;
    logic       wdt_tick;
    logic       wdt_timeout;
    logic       psc_out;
    logic       sample_en;
    logic       count_tick;

    modport core (output src_level, clear, hold, to_counter, ratio, wdt_tick, sample_en,
                  input wdt_timeout, count_tick);
    modport presc (input src_level, clear, hold, to_counter, ratio, wdt_tick,
                   output wdt_timeout, psc_out);
    modport sampler (input psc_out, sample_en, hold, output count_tick);
endinterface

// ### hdl/shared_prescaler.sv
// Eight-bit prescaler shared between the counter and the watchdog
`timescale 1ns/1ps
module shared_prescaler (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    timer_path_if.presc p
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       src_prev;
        logic       timeout;
    } psc_state_t;

    psc_state_t st;
    psc_state_t nx;
    logic [7:0] wdt_mask;

    // Watchdog ratio is two to the n, so compare the low n bits
    assign wdt_mask = 8'((16'h0001 << p.ratio) - 16'h0001);

    // Count source edges or watchdog ticks; the count itself is never visible
    always_comb begin
        nx          = st;
        nx.src_prev = p.src_level;
        nx.timeout  = 1'b0;
        if (p.clear) begin
            nx.cnt = 8'h00;
        end else if (p.to_counter) begin
            if (!p.hold && p.src_level && !st.src_prev) begin
                nx.cnt = st.cnt + 8'h01;
            end
        end else if (p.wdt_tick) begin
            if ((st.cnt & wdt_mask) == wdt_mask) begin
                nx.cnt     = 8'h00;
                nx.timeout = 1'b1;
            end else begin
                nx.cnt = st.cnt + 8'h01;
            end
        end
    end

    // Counter sees bit n (divide by two to n+1) or the bypassed source
    assign p.psc_out     = p.to_counter ? st.cnt[p.ratio] : st.src_prev;
    assign p.wdt_timeout = st.timeout;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Previous level starts high so a source already high after reset is no edge
            st <= '{cnt: 8'h00, src_prev: 1'b1, timeout: 1'b0};
        end else begin
            st <= nx;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_psc_clear_zero: assert property (p.clear |=> st.cnt == 8'h00)
        else $error("prescaler not cleared");
    chk_wdt_unit_ratio: assert property (p.wdt_tick && !p.to_counter && !p.clear && p.ratio == 3'h0
                                         |=> st.timeout)
        else $error("watchdog 1:1 tick lost");
endmodule

// ### hdl/phase_sampler.sv
// Samples the prescaler output on the second and fourth phase clocks
`timescale 1ns/1ps
module phase_sampler (
    input  wire logic     aclk,
    input  wire logic     aresetn,
    timer_path_if.sampler p
);
    typedef struct packed {
        logic sampled;
        logic tick;
    } smp_state_t;

    smp_state_t st;
    smp_state_t nx;

    // A rise between two samples makes one increment request
    always_comb begin
        nx      = st;
        nx.tick = p.sample_en && p.psc_out && !st.sampled && !p.hold;
        if (p.sample_en) begin
            nx.sampled = p.psc_out;
        end
    end

    assign p.count_tick = st.tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Start as if high was seen, avoiding a false tick right after reset
            st <= '{sampled: 1'b1, tick: 1'b0};
        end else begin
            st <= nx;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_tick_on_phase: assert property (st.tick |-> $past(p.sample_en))
        else $error("tick outside sample phase");
    chk_tick_single: assert property (st.tick |=> !st.tick)
        else $error("tick longer than one cycle");
endmodule

// ### hdl/ovf_timer_top.sv
// Prescaled 8-bit overflow counter with AXI4-Lite registers
// Function
// - 8-bit counter; wrapping from ff to 00 sets the overflow flag.
// - Clock source select zero: count instruction cycles, before prescaling.
// - Clock source select one: count edges of the external count pin.
// - Edge select zero counts rising edges, one counts falling edges.
// - Counting is suppressed for two instruction cycles after a counter write.
// - One prescaler serves counter or watchdog; watchdog use leaves counter at 1:1.
// - Prescaler assign zero routes it to counter, one to watchdog.
// - Three-bit ratio field; counter ratios span 1:2 to 1:256.
// - Prescaler count cannot be read or written by software.
// - Overflow flag sits at bit 2, sticky until software clears it.
// - Interrupt raised only when enable bit 5 and the flag are set.
// - Counter stops during sleep; overflow cannot wake the processor.
// - External signal passes the prescaler first, then is synchronised.
// - Counter write clears the prescaler when assigned to the counter.
// - Watchdog clear instruction clears the prescaler when assigned to watchdog.
// - Prescaler output sampled on second and fourth phase clocks.
`timescale 1ns/1ps
module ovf_timer_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        external_count_pin,
    input  wire logic        sleep_mode,
    input  wire logic        watchdog_tick,
    input  wire logic        watchdog_clear_instruction,
    output logic             watchdog_timeout,
    output logic             overflow_irq
);
    typedef struct packed {
        logic [1:0]  phase;
        logic [7:0]  count;
        logic [5:0]  cfg;
        logic        flag;
        logic        ovf_en;
        logic [3:0]  inhibit;
        logic        aw_held;
        logic        w_held;
        logic [4:0]  waddr;
        logic [7:0]  wdata;
        logic        wlane;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq;
    } core_state_t;

    localparam core_state_t ST_RESET = '{
        count:   ovf_timer_pkg::COUNT_RESET,
        cfg:     ovf_timer_pkg::CFG_RESET,
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        default: '0
    };

    core_state_t st;
    core_state_t nx;
    timer_path_if tp ();

    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic       aw_now;
    logic       w_now;
    logic [4:0] addr_now;
    logic [7:0] data_now;
    logic       lane_now;
    logic       wr_fire;
    logic       wr_en;
    logic       wr_mapped;
    logic       cnt_wr;
    logic       opt_wr;
    logic       clr_wr;
    logic       en_wr;
    logic       inc;
    logic       overflow;

    // Write address and data may arrive in either order; hold whichever came first
    assign aw_hs     = awvalid && st.awready;
    assign w_hs      = wvalid && st.wready;
    assign ar_hs     = arvalid && st.arready;
    assign aw_now    = st.aw_held || aw_hs;
    assign w_now     = st.w_held || w_hs;
    assign addr_now  = st.aw_held ? st.waddr : awaddr[4:0];
    assign data_now  = st.w_held ? st.wdata : wdata[7:0];
    assign lane_now  = st.w_held ? st.wlane : wstrb[0];
    assign wr_fire   = aw_now && w_now && !st.bvalid;
    assign wr_en     = wr_fire && lane_now;

    // Address decode; only byte lane 0 carries register data
    assign wr_mapped = (addr_now == ovf_timer_pkg::OFF_COUNT) || (addr_now == ovf_timer_pkg::OFF_OPTION)
                    || (addr_now == ovf_timer_pkg::OFF_STATUS) || (addr_now == ovf_timer_pkg::OFF_CLEAR)
                    || (addr_now == ovf_timer_pkg::OFF_ENABLE);
    assign cnt_wr    = wr_en && (addr_now == ovf_timer_pkg::OFF_COUNT);
    assign opt_wr    = wr_en && (addr_now == ovf_timer_pkg::OFF_OPTION);
    assign clr_wr    = wr_en && (addr_now == ovf_timer_pkg::OFF_CLEAR);
    assign en_wr     = wr_en && (addr_now == ovf_timer_pkg::OFF_ENABLE);

    // Increment requests are dropped while inhibited or asleep, not deferred
    assign inc       = tp.count_tick && (st.inhibit == 4'h0) && !sleep_mode;
    assign overflow  = inc && (st.count == ovf_timer_pkg::COUNT_MAX);

    // Source level: its rising edge is one counting event
    assign tp.src_level  = st.cfg[ovf_timer_pkg::CFG_CS_BIT]
                         ? (external_count_pin ^ st.cfg[ovf_timer_pkg::CFG_SE_BIT])
                         : st.phase[1];
    assign tp.to_counter = !st.cfg[ovf_timer_pkg::CFG_PSA_BIT];
    assign tp.ratio      = st.cfg[ovf_timer_pkg::CFG_RATIO_LSB +: ovf_timer_pkg::CFG_RATIO_W];
    assign tp.clear      = (cnt_wr && !st.cfg[ovf_timer_pkg::CFG_PSA_BIT])
                         || (watchdog_clear_instruction && st.cfg[ovf_timer_pkg::CFG_PSA_BIT]);
    assign tp.hold       = sleep_mode;
    assign tp.wdt_tick   = watchdog_tick;
    // Sampling after the prescaler lets the pin toggle faster than this logic
    assign tp.sample_en  = (st.phase == ovf_timer_pkg::PHASE_Q2)
                         || (st.phase == ovf_timer_pkg::PHASE_Q4);

    shared_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .p       (tp.presc)
    );

    phase_sampler u_sampler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .p       (tp.sampler)
    );

    // Next state: bus slave, counter, option and interrupt control
    always_comb begin
        nx       = st;
        nx.phase = st.phase + 2'h1;

        // Write channel, one write under way at a time
        nx.aw_held = aw_now && !wr_fire;
        nx.w_held  = w_now && !wr_fire;
        if (aw_hs) begin
            nx.waddr = awaddr[4:0];
        end
        if (w_hs) begin
            nx.wdata = wdata[7:0];
            nx.wlane = wstrb[0];
        end
        if (wr_fire) begin
            nx.bvalid = 1'b1;
            nx.bresp  = wr_mapped ? ovf_timer_pkg::RESP_OKAY : ovf_timer_pkg::RESP_SLVERR;
        end else if (st.bvalid && bready) begin
            nx.bvalid = 1'b0;
        end
        nx.awready = !nx.aw_held && !nx.bvalid;
        nx.wready  = !nx.w_held && !nx.bvalid;

        // Read channel; no address returns the prescaler count
        if (ar_hs) begin
            nx.rvalid = 1'b1;
            nx.rresp  = ovf_timer_pkg::RESP_OKAY;
            unique case (araddr[4:0])
                ovf_timer_pkg::OFF_COUNT: begin
                    nx.rdata = {24'h000000, st.count};
                end
                ovf_timer_pkg::OFF_OPTION: begin
                    nx.rdata = {26'h0000000, st.cfg};
                end
                ovf_timer_pkg::OFF_STATUS: begin
                    nx.rdata = 32'(st.flag) << ovf_timer_pkg::FLAG_BIT;
                end
                ovf_timer_pkg::OFF_CLEAR: begin
                    nx.rdata = 32'h00000000;
                end
                ovf_timer_pkg::OFF_ENABLE: begin
                    nx.rdata = 32'(st.ovf_en) << ovf_timer_pkg::EN_BIT;
                end
                default: begin
                    nx.rdata = 32'h00000000;
                    nx.rresp = ovf_timer_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && rready) begin
            nx.rvalid = 1'b0;
        end
        nx.arready = !nx.rvalid;

        // Counter: a write reloads and opens the inhibit window
        if (st.inhibit != 4'h0) begin
            nx.inhibit = st.inhibit - 4'h1;
        end
        if (cnt_wr) begin
            nx.count   = data_now;
            nx.inhibit = ovf_timer_pkg::INHIBIT_LOAD;
        end else if (inc) begin
            nx.count = st.count + 8'h01;
        end
        if (opt_wr) begin
            nx.cfg = data_now[5:0];
        end
        if (en_wr) begin
            nx.ovf_en = data_now[ovf_timer_pkg::EN_BIT];
        end

        // Overflow wins over a clear in the same cycle so no wrap is lost
        nx.flag = overflow || (st.flag && !(clr_wr && data_now[ovf_timer_pkg::FLAG_BIT]));
        nx.irq  = nx.flag && nx.ovf_en;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= ST_RESET;
        end else begin
            st <= nx;
        end
    end

    // Outputs straight from state flops
    assign awready          = st.awready;
    assign wready           = st.wready;
    assign bvalid           = st.bvalid;
    assign bresp            = st.bresp;
    assign arready          = st.arready;
    assign rvalid           = st.rvalid;
    assign rdata            = st.rdata;
    assign rresp            = st.rresp;
    assign overflow_irq     = st.irq;
    assign watchdog_timeout = tp.wdt_timeout;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cnt_write;
        cnt_wr;
    endsequence

    sequence s_no_inc8;
        (!inc)[*8];
    endsequence

    chk_ovf_sets_flag: assert property (overflow |=> st.flag && st.count == 8'h00)
        else $error("overflow did not wrap and flag");
    chk_flag_sticky: assert property (st.flag && !(clr_wr && data_now[ovf_timer_pkg::FLAG_BIT])
                                      |=> st.flag)
        else $error("flag cleared by hardware");
    chk_irq_gate: assert property (st.irq == (st.flag && st.ovf_en))
        else $error("interrupt without enabled flag");
    chk_write_inhibit: assert property (s_cnt_write |=> s_no_inc8)
        else $error("count advanced inside inhibit window");
    chk_sleep_hold: assert property (sleep_mode |-> !inc && !overflow)
        else $error("counter advanced during sleep");
    chk_timer_spacing: assert property (inc && !st.cfg[ovf_timer_pkg::CFG_CS_BIT]
                                        |=> (!inc)[*3])
        else $error("timer faster than instruction rate");
endmodule

// ### testbench/count_source.sv
// External count source driving the counter pin
`timescale 1ns/1ps
module count_source (
    input  wire logic aclk,
    input  wire logic run,
    output logic      pin
);
    // Half period of four clocks keeps each level above the two-clock minimum
    localparam int HALF = 4;
    int   cnt   = 0;
    logic level = 1'b0;

    assign pin = level;

    // Toggles only while running; stopped source holds its level
    always @(posedge aclk) begin
        if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) level <= ~level;
        end
    end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the prescaled overflow counter
`timescale 1ns/1ps
module testbench;
    typedef struct {
        logic [5:0] opt;
        logic       run;
        int         clks;
        logic [7:0] lo;
        logic [7:0] hi;
    } row_t;

    logic        aclk      = 1'b0;
    logic        aresetn   = 1'b0;
    logic [31:0] awaddr    = '0;
    logic        awvalid   = 1'b0;
    logic [31:0] wdata     = '0;
    logic        wvalid    = 1'b0;
    logic [31:0] araddr    = '0;
    logic        arvalid   = 1'b0;
    logic        sleep_mode = 1'b0;
    logic        wd_tick   = 1'b0;
    logic        wd_clear  = 1'b0;
    logic        run       = 1'b0;
    logic        pin;
    logic        awready, wready, bvalid, arready, rvalid, wd_timeout, overflow_irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, v;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          n_to       = 0;
    int          to_base    = 0;

    // Rows: option, source running, clocks to wait, count window
    row_t rows [8] = '{
        '{6'h08, 1'b0, 400,   8'h60, 8'h63},
        '{6'h0f, 1'b0, 400,   8'h60, 8'h63},
        '{6'h00, 1'b0, 800,   8'h61, 8'h64},
        '{6'h02, 1'b0, 3200,  8'h62, 8'h65},
        '{6'h07, 1'b0, 10240, 8'h09, 8'h0a},
        '{6'h28, 1'b1, 800,   8'h61, 8'h65},
        '{6'h38, 1'b1, 800,   8'h61, 8'h65},
        '{6'h20, 1'b1, 1600,  8'h60, 8'h65}
    };

    always #25 aclk = ~aclk;

    ovf_timer_top u_ovf_timer_top (
        .aclk                       (aclk),
        .aresetn                    (aresetn),
        .awaddr                     (awaddr),
        .awvalid                    (awvalid),
        .awready                    (awready),
        .wdata                      (wdata),
        .wstrb                      (4'hf),
        .wvalid                     (wvalid),
        .wready                     (wready),
        .bresp                      (bresp),
        .bvalid                     (bvalid),
        .bready                     (1'b1),
        .araddr                     (araddr),
        .arvalid                    (arvalid),
        .arready                    (arready),
        .rdata                      (rdata),
        .rresp                      (rresp),
        .rvalid                     (rvalid),
        .rready                     (1'b1),
        .external_count_pin         (pin),
        .sleep_mode                 (sleep_mode),
        .watchdog_tick              (wd_tick),
        .watchdog_clear_instruction (wd_clear),
        .watchdog_timeout           (wd_timeout),
        .overflow_irq               (overflow_irq)
    );

    count_source u_count_source (
        .aclk (aclk),
        .run  (run),
        .pin  (pin)
    );

    // Timeout pulses are single cycles, so count them at every edge
    always @(posedge aclk) if (wd_timeout === 1'b1) n_to <= n_to + 1;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Write with both channels offered together; valid lines hold until their ready is seen
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= 32'(a);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check("bresp", 32'(bresp), 32'(er));
    endtask

    // Waits for the answer however long it takes; only the time limit ends a hang
    task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= 32'(a);
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        check("rresp", 32'(rresp), 32'(er));
    endtask

    // Level output is looked at mid-cycle, away from the updating edge
    task automatic irq_chk(input logic e);
        @(negedge aclk);
        check("overflow_irq", 32'(overflow_irq), 32'(e));
        @(posedge aclk);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            wd_tick <= 1'b1;
            @(posedge aclk);
            wd_tick <= 1'b0;
            repeat (3) @(posedge aclk);
        end
    endtask

    task automatic wd_clr;
        wd_clear <= 1'b1;
        @(posedge aclk);
        wd_clear <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic reset_chk;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("outputs after reset", 32'({awready, wready, arready, bvalid, rvalid, overflow_irq, wd_timeout}), 32'h70);
        rd(ovf_timer_pkg::OFF_OPTION, v, ovf_timer_pkg::RESP_OKAY);
        check("option", v, 32'h3f);
        rd(ovf_timer_pkg::OFF_STATUS, v, ovf_timer_pkg::RESP_OKAY);
        check("status", v, 32'h0);
        rd(ovf_timer_pkg::OFF_ENABLE, v, ovf_timer_pkg::RESP_OKAY);
        check("enable", v, 32'h0);
        // Idle pin in falling-edge mode must not read as an edge after reset
        rd(ovf_timer_pkg::OFF_COUNT, v, ovf_timer_pkg::RESP_OKAY);
        check("count", v, 32'h0);
        $display("reset test done");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Rates need about 18k clocks in all; the limit leaves ample margin
    initial begin
        #(80000 * 50);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        reset_chk();
        // Rate table: a window absorbs sampling delay of a few clocks
        foreach (rows[i]) begin
            wr(ovf_timer_pkg::OFF_OPTION, 32'(rows[i].opt), ovf_timer_pkg::RESP_OKAY);
            run <= rows[i].run;
            wr(ovf_timer_pkg::OFF_COUNT, 32'h0, ovf_timer_pkg::RESP_OKAY);
            repeat (rows[i].clks) @(posedge aclk);
            rd(ovf_timer_pkg::OFF_COUNT, v, ovf_timer_pkg::RESP_OKAY);
            run <= 1'b0;
            check("count window", 32'(v[7:0] >= rows[i].lo && v[7:0] <= rows[i].hi), 32'h1);
            $display("rate test %0d done", i);
        end
        // Read-back at the last clock of the inhibit span; without it 1:1 would have stepped
        wr(ovf_timer_pkg::OFF_OPTION, 32'h08, ovf_timer_pkg::RESP_OKAY);
        wr(ovf_timer_pkg::OFF_COUNT, 32'h10, ovf_timer_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        rd(ovf_timer_pkg::OFF_COUNT, v, ovf_timer_pkg::RESP_OKAY);
        check("count inhibit", v, 32'h10);
        $display("inhibit test done");
        // Overflow with interrupt enabled, then frozen by sleep
        wr(ovf_timer_pkg::OFF_ENABLE, 32'h20, ovf_timer_pkg::RESP_OKAY);
        wr(ovf_timer_pkg::OFF_COUNT, 32'hfd, ovf_timer_pkg::RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(ovf_timer_pkg::OFF_STATUS, v, ovf_timer_pkg::RESP_OKAY);
        check("flag set", v, 32'h4);
        irq_chk(1'b1);
        sleep_mode <= 1'b1;
        wr(ovf_timer_pkg::OFF_COUNT, 32'h42, ovf_timer_pkg::RESP_OKAY);
        repeat (200) @(posedge aclk);
        rd(ovf_timer_pkg::OFF_COUNT, v, ovf_timer_pkg::RESP_OKAY);
        check("count asleep", v, 32'h42);
        rd(ovf_timer_pkg::OFF_STATUS, v, ovf_timer_pkg::RESP_OKAY);
        check("flag sticky", v, 32'h4);
        wr(ovf_timer_pkg::OFF_CLEAR, 32'h4, ovf_timer_pkg::RESP_OKAY);
        rd(ovf_timer_pkg::OFF_STATUS, v, ovf_timer_pkg::RESP_OKAY);
        check("flag cleared", v, 32'h0);
        irq_chk(1'b0);
        // Masked overflow still sets the flag but raises nothing
        wr(ovf_timer_pkg::OFF_ENABLE, 32'h0, ovf_timer_pkg::RESP_OKAY);
        sleep_mode <= 1'b0;
        wr(ovf_timer_pkg::OFF_COUNT, 32'hfd, ovf_timer_pkg::RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(ovf_timer_pkg::OFF_STATUS, v, ovf_timer_pkg::RESP_OKAY);
        check("flag masked", v, 32'h4);
        irq_chk(1'b0);
        wr(ovf_timer_pkg::OFF_CLEAR, 32'h4, ovf_timer_pkg::RESP_OKAY);
        wr(ovf_timer_pkg::OFF_ENABLE, 32'h20, ovf_timer_pkg::RESP_OKAY);
        irq_chk(1'b0);
        $display("overflow test done");
        // Count write restarts a 1:256 prescaler; its output first rises half a period later
        wr(ovf_timer_pkg::OFF_OPTION, 32'h07, ovf_timer_pkg::RESP_OKAY);
        wr(ovf_timer_pkg::OFF_COUNT, 32'h0, ovf_timer_pkg::RESP_OKAY);
        repeat (400) @(posedge aclk);
        rd(ovf_timer_pkg::OFF_COUNT, v, ovf_timer_pkg::RESP_OKAY);
        check("prescaler cleared", v, 32'h0);
        repeat (300) @(posedge aclk);
        rd(ovf_timer_pkg::OFF_COUNT, v, ovf_timer_pkg::RESP_OKAY);
        check("first prescaled step", v, 32'h1);
        $display("prescaler clear test done");
        // Watchdog side: ratio 3 gives one timeout per eight ticks
        wr(ovf_timer_pkg::OFF_OPTION, 32'h0b, ovf_timer_pkg::RESP_OKAY);
        wd_clr();
        to_base = n_to;
        ticks(8);
        check("timeouts", 32'(n_to - to_base), 32'h1);
        ticks(5);
        wd_clr();
        ticks(7);
        check("timeouts after clear", 32'(n_to - to_base), 32'h1);
        ticks(1);
        check("timeouts next", 32'(n_to - to_base), 32'h2);
        // Ratio zero passes every watchdog tick straight through
        wr(ovf_timer_pkg::OFF_OPTION, 32'h08, ovf_timer_pkg::RESP_OKAY);
        to_base = n_to;
        ticks(2);
        check("timeouts unit ratio", 32'(n_to - to_base), 32'h2);
        $display("watchdog test done");
        // Unmapped places answer with an error
        rd(5'h14, v, ovf_timer_pkg::RESP_SLVERR);
        check("unmapped data", v, 32'h0);
        wr(5'h14, 32'hff, ovf_timer_pkg::RESP_SLVERR);
        $display("unmapped test done");
        reset_chk();
        end_of_test();
    end
endmodule
